// ==== core/ciaes_bank.sv ====
`timescale 1ns/100ps

module ciaes_bank (
	// clock and resets
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	// configuration access port (host config space or SMBus slave)
	input wire logic cfg_req_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_smbus_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	// write lock for the next capability pointer
	input wire logic next_ptr_unlock_i,
	// rest of the port's configuration space
	output logic ext_req_o,
	output logic ext_wr_o,
	output logic [11:0] ext_addr_o,
	output logic [3:0] ext_be_o,
	output logic [31:0] ext_wdata_o,
	input wire logic [31:0] ext_rdata_i,
	// error events, one-cycle pulses from the port logic
	input wire logic err_link_protocol_i,
	input wire logic err_surprise_down_i,
	input wire logic surprise_down_report_capable_i,
	input wire logic err_poisoned_i,
	input wire logic err_flow_control_i,
	input wire logic err_unexpected_cpl_i,
	input wire logic err_rx_overflow_i,
	input wire logic err_malformed_i,
	input wire logic err_ecrc_i,
	input wire logic err_unsupported_i,
	// status for the error logging logic
	output logic [31:0] uncorrectable_error_status_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic at_offset(input logic [11:0] addr, input logic [11:0] ofs);
		at_offset = (addr[ciaes_pkg::ADDR_W-1:ciaes_pkg::DWORD_LO]
			== ofs[ciaes_pkg::ADDR_W-1:ciaes_pkg::DWORD_LO]);
	endfunction : at_offset

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	function automatic logic [31:0] merge(input logic [31:0] old_val,
			input logic [31:0] new_val, input logic [3:0] be);
		merge = (old_val & ~lane_mask(be)) | (new_val & lane_mask(be));
	endfunction : merge

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ciaes_pkg::ciaes_bank_state_t q;
	ciaes_pkg::ciaes_bank_state_t next_q;

	logic indirect;
	logic blocked;
	logic [11:0] target;
	logic hit_pointer;
	logic hit_cap;
	logic hit_status;
	logic hit_own;
	logic [31:0] pointer_word;
	logic [31:0] cap_word;
	logic [31:0] read_val;
	logic [31:0] merged;
	logic [31:0] status_clear;
	logic [31:0] status_val;
	logic [31:0] events;

	// ----------------------------------------------------------------
	// sticky error status
	// ----------------------------------------------------------------
	always_comb begin
		events = ciaes_pkg::STATUS_RESET;
		events[ciaes_pkg::ST_LINK_PROTOCOL] = err_link_protocol_i;
		events[ciaes_pkg::ST_SURPRISE_DOWN] = err_surprise_down_i;
		events[ciaes_pkg::ST_POISONED] = err_poisoned_i;
		events[ciaes_pkg::ST_FLOW_CONTROL] = err_flow_control_i;
		events[ciaes_pkg::ST_UNEXPECTED_CPL] = err_unexpected_cpl_i;
		events[ciaes_pkg::ST_RX_OVERFLOW] = err_rx_overflow_i;
		events[ciaes_pkg::ST_MALFORMED] = err_malformed_i;
		events[ciaes_pkg::ST_ECRC] = err_ecrc_i;
		events[ciaes_pkg::ST_UNSUPPORTED] = err_unsupported_i;
	end

	ciaes_status u_status (
		.sys_clk_i(sys_clk_i),
		.por_n_i(por_n_i),
		.events_i(events),
		.surprise_down_report_capable_i(surprise_down_report_capable_i),
		.clear_i(status_clear),
		.status_o(status_val)
	);

	// ----------------------------------------------------------------
	// target selection
	// ----------------------------------------------------------------
	always_comb begin
		indirect = at_offset(cfg_addr_i, ciaes_pkg::OFS_DATA);
		// the pointer always names a whole dword, so the low bits are zero
		target = indirect ? {q.pointer, 2'b00} : {cfg_addr_i[11:2], 2'b00};
		// SMBus may not use the window; the window may not point at itself
		blocked = indirect
			& (cfg_smbus_i | at_offset(target, ciaes_pkg::OFS_DATA));
		hit_pointer = at_offset(target, ciaes_pkg::OFS_POINTER);
		hit_cap = at_offset(target, ciaes_pkg::OFS_CAP_HEADER);
		hit_status = at_offset(target, ciaes_pkg::OFS_UNCOR_STATUS);
		hit_own = hit_pointer | hit_cap | hit_status
			| at_offset(target, ciaes_pkg::OFS_DATA);
	end

	// ----------------------------------------------------------------
	// register images
	// ----------------------------------------------------------------
	always_comb begin
		pointer_word = ciaes_pkg::DATA_ZERO;
		pointer_word[ciaes_pkg::ADDR_W-1:ciaes_pkg::DWORD_LO] = q.pointer;
		cap_word = ciaes_pkg::DATA_ZERO;
		cap_word[ciaes_pkg::CAP_VER_LO-1:ciaes_pkg::CAP_ID_LO]
			= ciaes_pkg::CAPABILITY_IDENTIFIER;
		cap_word[ciaes_pkg::NXT_PTR_LO-1:ciaes_pkg::CAP_VER_LO]
			= ciaes_pkg::CAPABILITY_VERSION;
		cap_word[31:ciaes_pkg::NXT_PTR_LO] = q.next_ptr;
	end

	always_comb begin
		if (hit_pointer) begin
			read_val = pointer_word;
		end else if (hit_cap) begin
			read_val = cap_word;
		end else if (hit_status) begin
			read_val = status_val;
		end else if (hit_own) begin
			read_val = ciaes_pkg::DATA_ZERO;
		end else begin
			read_val = ext_rdata_i;
		end
	end

	// ----------------------------------------------------------------
	// rest of the configuration space
	// ----------------------------------------------------------------
	// forwarded in the request cycle; the far side answers combinationally
	assign ext_req_o = cfg_req_i & ~blocked & ~hit_own;
	assign ext_wr_o = cfg_wr_i;
	assign ext_addr_o = target;
	assign ext_be_o = cfg_be_i;
	assign ext_wdata_o = cfg_wdata_i;

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	always_comb begin
		merged = ciaes_pkg::DATA_ZERO;
		status_clear = ciaes_pkg::DATA_ZERO;
		next_q = q;
		next_q.ack = cfg_req_i;
		if (cfg_req_i) begin
			// blocked window reads return zero instead of the target
			next_q.rdata = blocked ? ciaes_pkg::DATA_ZERO : read_val;
			if (cfg_wr_i && !blocked) begin
				if (hit_pointer) begin
					merged = merge(pointer_word, cfg_wdata_i, cfg_be_i);
					next_q.pointer = merged[ciaes_pkg::ADDR_W-1:ciaes_pkg::DWORD_LO];
				end
				if (hit_cap && next_ptr_unlock_i) begin
					merged = merge(cap_word, cfg_wdata_i, cfg_be_i);
					next_q.next_ptr = merged[31:ciaes_pkg::NXT_PTR_LO];
				end
				if (hit_status) begin
					status_clear = cfg_wdata_i & lane_mask(cfg_be_i);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// registers; the window itself holds no storage of its own
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			q.pointer <= ciaes_pkg::POINTER_RESET;
			q.next_ptr <= ciaes_pkg::NEXT_PTR_RESET;
			q.ack <= 1'b0;
			q.rdata <= ciaes_pkg::DATA_ZERO;
		end else begin
			q <= next_q;
		end
	end

	assign cfg_ack_o = q.ack;
	assign cfg_rdata_o = q.rdata;
	assign uncorrectable_error_status_o = status_val;

endmodule : ciaes_bank

// ==== core/ciaes_pkg.sv ====
package ciaes_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses, one dword each)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_POINTER = 12'h0f8;
	localparam logic [11:0] OFS_DATA = 12'h0fc;
	localparam logic [11:0] OFS_CAP_HEADER = 12'h100;
	localparam logic [11:0] OFS_UNCOR_STATUS = 12'h104;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DWORD_LO = 2;
	localparam int PTR_W = 10;
	localparam int CAP_ID_LO = 0;
	localparam int CAP_VER_LO = 16;
	localparam int NXT_PTR_LO = 20;
	localparam int NXT_PTR_W = 12;

	// ----------------------------------------------------------------
	// reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [15:0] CAPABILITY_IDENTIFIER = 16'h0001;
	localparam logic [3:0] CAPABILITY_VERSION = 4'h1;
	localparam logic [NXT_PTR_W-1:0] NEXT_PTR_RESET = 12'h200;
	localparam logic [PTR_W-1:0] POINTER_RESET = 10'h000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// uncorrectable error status bit positions
	// ----------------------------------------------------------------
	localparam int ST_OBSOLETE = 0;
	localparam int ST_LINK_PROTOCOL = 4;
	localparam int ST_SURPRISE_DOWN = 5;
	localparam int ST_POISONED = 12;
	localparam int ST_FLOW_CONTROL = 13;
	localparam int ST_COMPLETION_TIMEOUT = 14;
	localparam int ST_COMPLETER_ABORT = 15;
	localparam int ST_UNEXPECTED_CPL = 16;
	localparam int ST_RX_OVERFLOW = 17;
	localparam int ST_MALFORMED = 18;
	localparam int ST_ECRC = 19;
	localparam int ST_UNSUPPORTED = 20;
	localparam int ST_ACCESS_CONTROL = 21;

	// bits that hardware may ever set; everything else reads zero
	localparam logic [31:0] STATUS_SETTABLE = 32'h001f_3030;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PTR_W-1:0] pointer;
		logic [NXT_PTR_W-1:0] next_ptr;
		logic ack;
		logic [31:0] rdata;
	} ciaes_bank_state_t;

	typedef struct packed {
		logic [31:0] status;
	} ciaes_status_state_t;

endpackage : ciaes_pkg

// ==== core/ciaes_status.sv ====
`timescale 1ns/100ps

module ciaes_status (
	// clock and power-on reset
	input wire logic sys_clk_i,
	input wire logic por_n_i,
	// error events, bit-aligned to the status layout
	input wire logic [31:0] events_i,
	input wire logic surprise_down_report_capable_i,
	// write-one-to-clear strobe
	input wire logic [31:0] clear_i,
	// register contents
	output logic [31:0] status_o
);

	ciaes_pkg::ciaes_status_state_t q;
	ciaes_pkg::ciaes_status_state_t next_q;
	logic [31:0] set_vec;

	always_comb begin
		set_vec = events_i;
		// surprise down only counts when the link advertises reporting
		set_vec[ciaes_pkg::ST_SURPRISE_DOWN] = events_i[ciaes_pkg::ST_SURPRISE_DOWN]
			& surprise_down_report_capable_i;
		// obsolete, hardwired and reserved positions never latch
		set_vec = set_vec & ciaes_pkg::STATUS_SETTABLE;
		next_q = q;
		// a set in the same cycle as its clear wins, so no event is lost
		next_q.status = ((q.status & ~clear_i) | set_vec)
			& ciaes_pkg::STATUS_SETTABLE;
	end

	// sticky: only the power-on reset or a write-one-to-clear returns these bits to zero
	always_ff @(posedge sys_clk_i) begin
		if (!por_n_i) begin
			q.status <= ciaes_pkg::STATUS_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign status_o = q.status;

endmodule : ciaes_status

// ==== testbench/ciaes_bank_chk.sv ====
`timescale 1ns/100ps

module ciaes_bank_chk (
	// clock and resets
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	// access port
	input wire logic cfg_req_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_smbus_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic ext_req_o,
	// error side
	input wire logic err_link_protocol_i,
	input wire logic err_surprise_down_i,
	input wire logic surprise_down_report_capable_i,
	input wire logic [31:0] uncorrectable_error_status_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);
	wire logic win = cfg_addr_i[11:2] == 10'h03f;
	wire logic [31:0] st = uncorrectable_error_status_o;

	sequence smb_win_read;
		cfg_req_i && !cfg_wr_i && cfg_smbus_i && win;
	endsequence
	sequence zero_answer;
		cfg_ack_o && cfg_rdata_o == 32'h0;
	endsequence

	ack_next_a: assert property (cfg_req_i |=> cfg_ack_o)
		else $error("no ack after request");
	ack_only_a: assert property (!cfg_req_i |=> !cfg_ack_o && $stable(cfg_rdata_o))
		else $error("ack or data change without request");
	smb_fwd_a: assert property (cfg_req_i && cfg_smbus_i && win |-> !ext_req_o)
		else $error("smbus window access forwarded");
	smb_zero_a: assert property (smb_win_read |=> zero_answer)
		else $error("smbus window read not zero");
	cap_hdr_a: assert property (cfg_req_i && !cfg_wr_i && cfg_addr_i[11:2] == 10'h040
		|=> cfg_rdata_o[19:0] == 20'h10001)
		else $error("capability header fixed fields wrong");
	fixed_zero_a: assert property ((st & 32'hffe0_cfcf) == 32'h0)
		else $error("hardwired status bit set");
	link_set_a: assert property (err_link_protocol_i |=> st[4])
		else $error("link protocol event not recorded");
	sd_gate_a: assert property (err_surprise_down_i && !surprise_down_report_capable_i
		&& !st[5] |=> !st[5])
		else $error("surprise down set while not capable");
	sticky_hold_a: assert property (disable iff (!por_n_i) !rst_n_i |=> $stable(st))
		else $error("status lost in plain reset");
endmodule : ciaes_bank_chk

bind ciaes_bank ciaes_bank_chk ciaes_bank_chk_i (.sys_clk_i, .rst_n_i, .por_n_i, .cfg_req_i,
	.cfg_wr_i, .cfg_smbus_i, .cfg_addr_i, .cfg_ack_o, .cfg_rdata_o, .ext_req_o,
	.err_link_protocol_i, .err_surprise_down_i, .surprise_down_report_capable_i,
	.uncorrectable_error_status_o);

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
	logic clk, rst_n, por_n, req, wr, smb, unlock, cap, ack, ext_req, ext_wr, w;
	logic [11:0] addr, ext_addr, p;
	logic [3:0] be, ext_be, b;
	logic [31:0] wdata, rdata, ext_wdata, ext_rdata, st, rd, x, xw, exp_st, d;
	logic [8:0] evt, e;
	int err_count = 0;
	int total_checks = 0;
	int pos[9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

	ciaes_bank ciaes_bank_i (.sys_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .cfg_req_i(req),
		.cfg_wr_i(wr), .cfg_smbus_i(smb), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
		.cfg_ack_o(ack), .cfg_rdata_o(rdata), .next_ptr_unlock_i(unlock), .ext_req_o(ext_req),
		.ext_wr_o(ext_wr), .ext_addr_o(ext_addr), .ext_be_o(ext_be), .ext_wdata_o(ext_wdata),
		.ext_rdata_i(ext_rdata), .err_link_protocol_i(evt[0]), .err_surprise_down_i(evt[1]),
		.surprise_down_report_capable_i(cap), .err_poisoned_i(evt[2]),
		.err_flow_control_i(evt[3]), .err_unexpected_cpl_i(evt[4]), .err_rx_overflow_i(evt[5]),
		.err_malformed_i(evt[6]), .err_ecrc_i(evt[7]), .err_unsupported_i(evt[8]),
		.uncorrectable_error_status_o(st));

	// far side shows the inverted pattern when not addressed
	function logic [31:0] far(input logic [11:0] a);
		far = {20'hc3a5e, a};
	endfunction : far
	assign ext_rdata = ext_req ? far(ext_addr) : ~far(ext_addr);

	function logic [31:0] emask(input logic [8:0] v, input logic c);
		emask = 32'h0;
		for (int i = 0; i < 9; i++)
			if (v[i] && (i != 1 || c))
				emask[pos[i]] = 1'b1;
	endfunction : emask

	function logic [31:0] lanes(input logic [3:0] m);
		lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction : lanes

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task acc(input logic aw, as, input logic [11:0] a, input logic [3:0] ab, input logic [31:0] ad);
		@(posedge clk);
		req <= 1'b1;
		wr <= aw;
		smb <= as;
		addr <= a;
		be <= ab;
		wdata <= ad;
		#1;
		x = {12'h0, ext_req, ext_wr, ext_be, ext_addr, 2'b00};
		xw = ext_wdata;
		@(posedge clk);
		req <= 1'b0;
		#1;
		check({31'h0, ack}, 32'h1);
		rd = rdata;
	endtask : acc

	task pulse(input logic [8:0] v, input logic c);
		@(posedge clk);
		evt <= v;
		cap <= c;
		@(posedge clk);
		evt <= 9'h0;
		exp_st = exp_st | emask(v, c);
	endtask : pulse

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial begin
		void'($urandom(32'haa92ed58));
		{rst_n, por_n, req, wr, smb, unlock, cap, evt, addr, be, wdata} = '0;
		exp_st = 32'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		acc(0, 0, 12'h0f8, 4'hf, 32'h0);
		check(rd, 32'h0);
		acc(0, 0, 12'h100, 4'hf, 32'h0);
		check(rd, 32'h2001_0001);
		// ----------------------------------------------------------------
		// window to random far registers
		// ----------------------------------------------------------------
		repeat (10) begin
			p = {4'($urandom_range(15, 2)), 6'($urandom), 2'b00};
			d = $urandom;
			b = 4'($urandom);
			w = 1'($urandom);
			acc(1, 0, 12'h0f8, 4'hf, {20'($urandom), p[11:2], 2'b11});
			acc(0, 0, 12'h0f8, 4'hf, 32'h0);
			check(rd, {20'h0, p});
			acc(w, 0, 12'h0fc, b, d);
			check(x, {12'h0, 1'b1, w, b, p, 2'b00});
			check(xw, d);
			if (!w)
				check(rd, far(p));
		end
		// ----------------------------------------------------------------
		// error events, random and a full sweep with surprise down gated
		// ----------------------------------------------------------------
		pulse(9'h1ff, 1'b0);
		repeat (12) begin
			e = 9'($urandom);
			pulse(e, 1'($urandom));
			acc(0, 0, 12'h104, 4'hf, 32'h0);
			check(rd, exp_st);
			check(st, exp_st);
			b = 4'($urandom);
			d = $urandom;
			acc(1, 0, 12'h104, b, d);
			exp_st = exp_st & ~(d & lanes(b));
			check(st, exp_st);
		end
		pulse(9'h1ff, 1'b1);
		// ----------------------------------------------------------------
		// window corner cases, pointer aimed at the status, window and pointer registers
		// ----------------------------------------------------------------
		acc(1, 0, 12'h0f8, 4'hf, 32'h104);
		acc(0, 1, 12'h0fc, 4'hf, 32'h0);
		check(rd, 32'h0);
		acc(1, 1, 12'h0fc, 4'hf, 32'hffff_ffff);
		check(st, exp_st);
		acc(0, 0, 12'h0fc, 4'hf, 32'h0);
		check(rd, exp_st);
		acc(1, 0, 12'h0fc, 4'h2, 32'hffff_ffff);
		exp_st = exp_st & 32'hffff_00ff;
		check(st, exp_st);
		acc(1, 0, 12'h0f8, 4'hf, 32'h0fc);
		acc(0, 0, 12'h0fc, 4'hf, 32'h0);
		check(rd, 32'h0);
		acc(1, 0, 12'h0fc, 4'hf, 32'h104);
		acc(0, 0, 12'h0f8, 4'hf, 32'h0);
		check(rd, 32'h0fc);
		acc(1, 0, 12'h0f8, 4'hf, 32'h0f8);
		acc(1, 0, 12'h0fc, 4'hf, 32'h104);
		acc(0, 0, 12'h0f8, 4'hf, 32'h0);
		check(rd, 32'h104);
		// ----------------------------------------------------------------
		// next pointer lock, plain reset, power-on reset
		// ----------------------------------------------------------------
		@(posedge clk);
		unlock <= 1'b1;
		acc(1, 0, 12'h100, 4'hc, 32'h3abf_ffff);
		@(posedge clk);
		unlock <= 1'b0;
		acc(1, 0, 12'h100, 4'hf, 32'hfff0_0000);
		acc(0, 0, 12'h100, 4'hf, 32'h0);
		check(rd, 32'h3ab1_0001);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		acc(0, 0, 12'h100, 4'hf, 32'h0);
		check(rd, 32'h2001_0001);
		check(st, exp_st);
		@(posedge clk);
		por_n <= 1'b0;
		@(posedge clk);
		por_n <= 1'b1;
		acc(0, 0, 12'h104, 4'hf, 32'h0);
		check(rd, 32'h0);
		finish_test();
	end
endmodule : tb_top
